/* File: design/pac_pkg.sv */
// Function
// - Local vector reads back what was written.
// - Acknowledge copies upper five bits into vector.
// - Acknowledge cycle drives selected vector onto bus.
// - Low three type bits stored, no effect.
// - Prescaler ticks every 250, or 2 clocks.
// - Stale timer divides ticks by ten unless bypassed.
// - Both short bits: advance every other clock.
// - Stale mask gates status and interrupt sources.
// - Lockout refuses channel data, FIFO appears full.
// - Lockout in ECP forward withholds event 36.
// - Clear-timeout bit clears and holds timeout status.
// - Clear-timeout held blocks single-character interrupt.
// - Async DMA bit synchronises DMA grant input.
// - Unfair bit posts serial requests despite shared line.
package pac_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_LOCAL_VECTOR = 10'h018;
  localparam logic [9:0] IDX_AUX_CONTROL = 10'h03F;
  localparam logic [9:0] IDX_STATUS = 10'h040;

  // Reset values of the writable registers.
  localparam logic [7:0] LOCAL_VECTOR_RST = 8'h00;
  localparam logic [7:0] AUX_CONTROL_RST = 8'h00;

  // Field positions in the auxiliary control register.
  localparam int SHORT_TICK_BIT = 7;
  localparam int SHORT_STALE_BIT = 6;
  localparam int STALE_MASK_BIT = 5;
  localparam int FIFO_LOCKOUT_BIT = 4;
  localparam int CLEAR_TIMEOUT_BIT = 3;
  localparam int RESERVED_BIT = 2;
  localparam int ASYNC_DMA_BIT = 1;
  localparam int UNFAIR_BIT = 0;

  // Mask of bits that hold state; the reserved bit reads zero.
  localparam logic [7:0] AUX_WRITE_MASK = 8'hFB;

  // Service types, also the index into the vector array.
  localparam int TYPE_MODEM = 0;
  localparam int TYPE_PARALLEL = 1;
  localparam int TYPE_TRANSMIT = 2;
  localparam int TYPE_RECEIVE = 3;

  // Type codes merged under the five seed bits of a vector.
  localparam logic [2:0] CODE_MODEM = 3'h1;
  localparam logic [2:0] CODE_PARALLEL = 3'h3;
  localparam logic [2:0] CODE_TRANSMIT = 3'h2;
  localparam logic [2:0] CODE_RECEIVE = 3'h4;

  // Prescaler periods in clocks, normal and shortened.
  localparam int TICK_PERIOD = 250;
  localparam int TICK_PERIOD_SHORT = 2;
  // Stale timer divider in prescaler ticks.
  localparam int STALE_DIVIDE = 10;

endpackage : pac_pkg

/* File: design/parallel_aux_control_and_vector.sv */
// Our own choice: the APB register port.
module parallel_aux_control_and_vector (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Service request pins, one per type, active low; req_pending is active high.
  input wire logic [3:0] service_ack_n,
  input wire logic [3:0] service_line_n,
  input wire logic [3:0] req_pending,
  output logic [3:0] service_req_n,
  // Acknowledge read data bus.
  output logic [7:0] ack_db,
  output logic ack_db_en,
  // DMA grant pin and its cleaned form.
  input wire logic dma_grant_n,
  output logic dma_grant,
  // Parallel channel side.
  input wire logic channel_stale,
  input wire logic one_char_cond,
  input wire logic timeout_event,
  input wire logic chan_wr_valid,
  input wire logic fifo_full,
  input wire logic ecp_forward,
  input wire logic event36_req,
  input wire logic host_recovery,
  output logic fifo_accept,
  output logic fifo_full_seen,
  output logic event36,
  output logic discard_byte,
  // Timer and status outputs.
  output logic stale_advance,
  output logic stale_status,
  output logic timeout_status,
  output logic single_char_irq
);

  // Software registers.
  logic [7:0] local_vector_seed;
  logic [7:0] parallel_aux_control;
  // Per-type vector registers, indexed by service type.
  logic [7:0] vector_reg [4];

  // Named control bits.
  logic short_tick;
  logic short_stale;
  logic stale_mask;
  logic fifo_lockout;
  logic clear_timeout;
  logic async_dma_sync;
  logic unfair;
  assign short_tick = parallel_aux_control[pac_pkg::SHORT_TICK_BIT];
  assign short_stale = parallel_aux_control[pac_pkg::SHORT_STALE_BIT];
  assign stale_mask = parallel_aux_control[pac_pkg::STALE_MASK_BIT];
  assign fifo_lockout = parallel_aux_control[pac_pkg::FIFO_LOCKOUT_BIT];
  assign clear_timeout = parallel_aux_control[pac_pkg::CLEAR_TIMEOUT_BIT];
  assign async_dma_sync = parallel_aux_control[pac_pkg::ASYNC_DMA_BIT];
  assign unfair = parallel_aux_control[pac_pkg::UNFAIR_BIT];

  // Decode of a register index; used by both write and read paths.
  function automatic logic is_reg(input logic [11:0] a,
                                  input logic [9:0] idx);
    is_reg = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction : is_reg

  // Bus strobes.
  logic setup;
  logic access;
  logic wr_en;
  logic mapped;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign mapped = is_reg(paddr, pac_pkg::IDX_LOCAL_VECTOR) ||
                  is_reg(paddr, pac_pkg::IDX_AUX_CONTROL) ||
                  is_reg(paddr, pac_pkg::IDX_STATUS);

  // Zero wait states; unmapped accesses answer with an error.
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Pin synchronisers: ack, shared line and DMA grant in one vector.
  // A change is accepted only once stages two and three agree.
  logic [8:0] pins;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] sync3;
  logic [8:0] filt;
  assign pins = {dma_grant_n, service_line_n, service_ack_n};

  // Three stage chain; inactive pins idle high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 9'h1FF;
      sync2 <= 9'h1FF;
      sync3 <= 9'h1FF;
      filt <= 9'h1FF;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    end
  end

  // Active-high views of the filtered pins.
  logic [3:0] ack_act;
  logic [3:0] ack_prev;
  logic [3:0] ack_start;
  logic [3:0] line_busy;
  logic [3:0] posted;
  assign ack_act = ~filt[3:0];
  assign line_busy = ~filt[7:4];
  assign ack_start = ack_act & ~ack_prev;
  assign service_req_n = ~posted;

  // Software register writes; writes to status are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_vector_seed <= pac_pkg::LOCAL_VECTOR_RST;
      parallel_aux_control <= pac_pkg::AUX_CONTROL_RST;
    end else if (wr_en) begin
      if (is_reg(paddr, pac_pkg::IDX_LOCAL_VECTOR)) begin
        local_vector_seed <= pwdata[7:0];
      end
      if (is_reg(paddr, pac_pkg::IDX_AUX_CONTROL)) begin
        parallel_aux_control <= pwdata[7:0] & pac_pkg::AUX_WRITE_MASK;
      end
    end
  end

  // Read data is captured in the setup phase so it is steady in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (is_reg(paddr, pac_pkg::IDX_LOCAL_VECTOR)) begin
        prdata <= {24'h00_0000, local_vector_seed};
      end else if (is_reg(paddr, pac_pkg::IDX_AUX_CONTROL)) begin
        prdata <= {24'h00_0000, parallel_aux_control};
      end else if (is_reg(paddr, pac_pkg::IDX_STATUS)) begin
        prdata <= {24'h00_0000, posted, fifo_full_seen,
                   single_char_irq, stale_status, timeout_status};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Fair share posting; once posted a request holds while pending.
  // The parallel type ignores the shared line, so never waits on it.
  genvar q;
  generate
    for (q = 0; q < 4; q++) begin : g_post
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          posted[q] <= 1'b0;
        end else begin
          posted[q] <= req_pending[q] && (posted[q] || unfair ||
            !line_busy[q] || (q == pac_pkg::TYPE_PARALLEL));
        end
      end
    end
  endgenerate

  // Type code constant for each vector slot.
  logic [2:0] type_code [4];
  assign type_code[pac_pkg::TYPE_MODEM] = pac_pkg::CODE_MODEM;
  assign type_code[pac_pkg::TYPE_PARALLEL] = pac_pkg::CODE_PARALLEL;
  assign type_code[pac_pkg::TYPE_TRANSMIT] = pac_pkg::CODE_TRANSMIT;
  assign type_code[pac_pkg::TYPE_RECEIVE] = pac_pkg::CODE_RECEIVE;

  // Vector merge, one slot per type.
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_vec
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          vector_reg[t] <= 8'h00;
        end else if (ack_start[t] && posted[t]) begin
          vector_reg[t] <= {local_vector_seed[7:3], type_code[t]};
        end
      end
    end
  endgenerate

  // Acknowledge read cycle; the lowest active type wins a collision.
  logic [1:0] ack_sel;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_prev <= 4'h0;
      ack_db_en <= 1'b0;
      ack_sel <= 2'h0;
    end else begin
      ack_prev <= ack_act;
      ack_db_en <= 1'b0;
      for (int i = 3; i >= 0; i--) begin
        if (ack_act[i] && (posted[i] || (ack_db_en && ack_sel == i))) begin
          ack_db_en <= 1'b1;
          ack_sel <= 2'(i);
        end
      end
    end
  end

  assign ack_db = ack_db_en ? vector_reg[ack_sel] : 8'h00;

  // Prescaler for the stale data timer.
  logic [7:0] pre_cnt;
  logic [7:0] pre_last;
  logic tick;
  // A count left above a freshly shortened period restarts at once.
  assign pre_last = short_tick ? 8'(pac_pkg::TICK_PERIOD_SHORT - 1)
                               : 8'(pac_pkg::TICK_PERIOD - 1);
  assign tick = (pre_cnt == pre_last);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 8'h00;
    end else if (pre_cnt >= pre_last) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // Divide by ten of prescaler ticks, bypassed by the short bit.
  // With both short bits this yields one advance every other clock.
  logic [3:0] div_cnt;
  logic div_done;
  assign div_done = (div_cnt == 4'(pac_pkg::STALE_DIVIDE - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 4'h0;
      stale_advance <= 1'b0;
    end else begin
      stale_advance <= tick && (short_stale || div_done);
      if (tick) begin
        div_cnt <= (div_done || short_stale) ? 4'h0 : div_cnt + 4'h1;
      end
    end
  end

  // Timeout latch; a held clear bit overrides any new event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_status <= 1'b0;
    end else if (clear_timeout) begin
      timeout_status <= 1'b0;
    end else if (timeout_event) begin
      timeout_status <= 1'b1;
    end
  end

  // Stale status and single character interrupt condition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stale_status <= 1'b0;
      single_char_irq <= 1'b0;
    end else begin
      stale_status <= channel_stale && !stale_mask;
      single_char_irq <= one_char_cond && timeout_status &&
                         !stale_mask && !clear_timeout;
    end
  end

  assign fifo_accept = chan_wr_valid && !fifo_full && !fifo_lockout;
  assign fifo_full_seen = fifo_full || fifo_lockout;

  // Event 36 is withheld under lockout in ECP forward; recovery there drops the byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event36 <= 1'b0;
      discard_byte <= 1'b0;
    end else begin
      event36 <= event36_req && !(fifo_lockout && ecp_forward);
      discard_byte <= host_recovery && fifo_lockout && ecp_forward;
    end
  end

  // Grant is synchronised only when asked; the sync path costs latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_grant <= 1'b0;
    end else begin
      dma_grant <= async_dma_sync ? !filt[8] : !dma_grant_n;
    end
  end

  // Checks.
  logic both_short;
  assign both_short = short_tick && short_stale;

  lvs_readback_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !pwrite && is_reg(paddr, pac_pkg::IDX_LOCAL_VECTOR)
    |-> prdata[7:0] == local_vector_seed)
    else $error("Local vector readback differs.");

  vec_merge_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ack_start[1] && posted[1]
    |=> vector_reg[1][7:3] == $past(local_vector_seed[7:3]))
    else $error("Vector merge lost seed bits.");

  ack_drive_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ack_db_en |-> ack_db == vector_reg[ack_sel])
    else $error("Acknowledge bus carries wrong vector.");

  type_bits_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, pac_pkg::IDX_LOCAL_VECTOR)
    |=> local_vector_seed[2:0] == $past(pwdata[2:0]))
    else $error("Type bits not stored.");

  tick_period_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && !short_tick |-> pre_cnt == 8'(pac_pkg::TICK_PERIOD - 1))
    else $error("Prescaler tick at wrong count.");

  fast_rate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    stale_advance && $past(both_short) && both_short
    |=> !stale_advance)
    else $error("Stale timer advanced on adjacent clocks.");

  stale_mask_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(stale_mask) |-> !stale_status && !single_char_irq)
    else $error("Masked stale status visible.");

  lockout_full_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fifo_lockout |-> !fifo_accept && fifo_full_seen)
    else $error("Lockout did not refuse data.");

  ev36_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(fifo_lockout && ecp_forward) |-> !event36)
    else $error("Event 36 sent under lockout.");

  timeout_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_timeout ##1 clear_timeout |-> !timeout_status)
    else $error("Timeout status survived clear.");

  single_char_irq_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(clear_timeout) |-> !single_char_irq)
    else $error("Single char condition while clear held.");

  unfair_post_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    unfair && req_pending[2] |=> posted[2])
    else $error("Unfair request not posted.");

  ack_cycle_c: cover property (@(posedge pclk) disable iff (!presetn)
    ack_start[0] && posted[0] ##1 ack_db_en);
  fast_timer_c: cover property (@(posedge pclk) disable iff (!presetn)
    both_short && stale_advance ##2 stale_advance);
  lockout_c: cover property (@(posedge pclk) disable iff (!presetn)
    fifo_lockout && ecp_forward && host_recovery);

endmodule : parallel_aux_control_and_vector

/* File: tb/ack_host.sv */
module ack_host (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bench control: go arms one cycle, slow stretches the hold.
  input wire logic go,
  input wire logic slow,
  // Device side of the acknowledge cycle.
  input wire logic [3:0] service_req_n,
  input wire logic [7:0] ack_db,
  input wire logic ack_db_en,
  output logic [3:0] service_ack_n,
  // Captured vector and completion flag.
  output logic [7:0] got,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  // Phase of the acknowledge cycle.
  logic [1:0] st;
  // Wait and hold counter.
  logic [4:0] cnt;
  // Posted requests as an active-high mask.
  logic [3:0] low;
  assign low = ~service_req_n;
  assign done = (st == 2'h3);
  // Acknowledge read cycle.
  // The pin is held until the vector is seen or the count reaches 31, so no short cycle occurs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= 2'h0;
      cnt <= 5'h00;
      got <= 8'h00;
      service_ack_n <= 4'hF;
    end else begin
      case (st)
        // Acknowledge the lowest posted type only.
        2'h0: if (go && low != 4'h0) begin
          service_ack_n <= ~(low & (~low + 4'h1));
          cnt <= 5'h00;
          st <= 2'h1;
        end
        // Take the vector at the edge that shows it driven.
        2'h1: begin
          cnt <= cnt + 5'h01;
          if (ack_db_en || cnt == 5'h1F) begin
            got <= ack_db;
            cnt <= slow ? 5'h03 : 5'h00;
            st <= 2'h2;
          end
        end
        // Release after the optional hold.
        2'h2: begin
          cnt <= cnt - 5'h01;
          if (cnt == 5'h00) begin
            service_ack_n <= 4'hF;
            st <= 2'h3;
          end
        end
        // Wait for the bench to disarm.
        default: if (!go) begin
          st <= 2'h0;
        end
      endcase
    end
  end
endmodule : ack_host

/* File: tb/tb_parallel_aux_control_and_vector.sv */
module tb_parallel_aux_control_and_vector;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench-driven inputs, all given a value at time zero.
  logic pclk = 1'b0, presetn = 1'b0, go = 1'b0, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] service_line_n = 4'hF, req_pending = 4'h0;
  logic dma_grant_n = 1'b1, channel_stale = 1'b0, one_char_cond = 1'b0;
  logic timeout_event = 1'b0, chan_wr_valid = 1'b0, fifo_full = 1'b0;
  logic ecp_forward = 1'b0, event36_req = 1'b0, host_recovery = 1'b0;
  // Design outputs.
  logic [31:0] prdata;
  logic [3:0] service_ack_n, service_req_n;
  logic [7:0] ack_db, got;
  logic pready, pslverr, ack_db_en, dma_grant, done;
  logic fifo_accept, fifo_full_seen, event36, discard_byte;
  logic stale_advance, stale_status, timeout_status, single_char_irq;
  // Last read data and error, and the tallies.
  logic [31:0] rdat;
  logic err;
  int mismatches = 0;
  int comparisons = 0;
  localparam logic [11:0] A_VEC = {pac_pkg::IDX_LOCAL_VECTOR, 2'b00};
  localparam logic [11:0] A_AUX = {pac_pkg::IDX_AUX_CONTROL, 2'b00};
  localparam logic [11:0] A_STAT = {pac_pkg::IDX_STATUS, 2'b00};
  localparam logic [2:0] CODES [4] = '{pac_pkg::CODE_MODEM,
    pac_pkg::CODE_PARALLEL, pac_pkg::CODE_TRANSMIT, pac_pkg::CODE_RECEIVE};

  // Free-running 40 MHz clock.
  always #12.5 pclk = ~pclk;

  parallel_aux_control_and_vector DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .service_ack_n,
    .service_line_n, .req_pending, .service_req_n, .ack_db, .ack_db_en,
    .dma_grant_n, .dma_grant, .channel_stale, .one_char_cond,
    .timeout_event, .chan_wr_valid, .fifo_full, .ecp_forward, .event36_req,
    .host_recovery, .fifo_accept, .fifo_full_seen, .event36, .discard_byte,
    .stale_advance, .stale_status, .timeout_status, .single_char_irq);

  ack_host host (.pclk, .presetn, .go, .slow, .service_req_n, .ack_db,
    .ack_db_en, .service_ack_n, .got, .done);

  // Compare one value and tally the outcome.
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Print the tallies and the verdict, then stop.
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Let n edges pass and sample just after the last.
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc

  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reset values, read-back and an unmapped place.
  task t_regs;
    apb(1'b0, A_VEC, 8'h00);
    chk("vec_reset", rdat, 32'h00000000);
    apb(1'b0, A_AUX, 8'h00);
    chk("aux_reset", rdat, 32'h00000000);
    apb(1'b1, A_VEC, 8'hA5);
    apb(1'b0, A_VEC, 8'h00);
    chk("vec_rw", rdat, 32'h000000A5);
    apb(1'b1, A_AUX, 8'hFB);
    apb(1'b0, A_AUX, 8'h00);
    chk("aux_rw", rdat, {24'h000000, pac_pkg::AUX_WRITE_MASK});
    apb(1'b0, 12'h800, 8'h00);
    chk("unmapped", {err, rdat[30:0]}, 32'h80000000);
    apb(1'b1, A_AUX, 8'h00);
  endtask : t_regs

  // each type merges the seed and drives its vector.
  task t_ack;
    int i;
    apb(1'b1, A_VEC, 8'hAD);
    for (int t = 0; t < 4; t++) begin
      @(posedge pclk);
      req_pending <= 4'h1 << t;
      go <= 1'b1;
      slow <= t[0];
      i = 0;
      do begin
        @(posedge pclk);
        i++;
      end while (done !== 1'b1 && i < 64);
      if (done !== 1'b1) begin
        mismatches++;
        wrap_up();
      end
      chk("ack_vec", got, {24'h000000, 5'h15, CODES[t]});
      req_pending <= 4'h0;
      go <= 1'b0;
      cyc(8);
      chk("ack_drop", {ack_db_en, ack_db}, 32'h00000000);
    end
    apb(1'b0, A_VEC, 8'h00);
    chk("vec_keep", rdat, 32'h000000AD);
  endtask : t_ack

  // Busy shared lines block serial types unless unfair.
  task t_fair;
    @(posedge pclk);
    service_line_n <= 4'h0;
    // Let the line sense settle before any request can post.
    cyc(6);
    @(posedge pclk);
    req_pending <= 4'hE;
    cyc(4);
    chk("fair", service_req_n, 32'h0000000D);
    apb(1'b1, A_AUX, 8'h01);
    cyc(3);
    chk("unfair", service_req_n, 32'h00000001);
    @(posedge pclk);
    req_pending <= 4'h0;
    service_line_n <= 4'hF;
    apb(1'b1, A_AUX, 8'h00);
  endtask : t_fair

  // every timer mode yields two advances in two periods.
  task t_timer;
    int p;
    int c;
    for (int m = 3; m >= 0; m--) begin
      p = m[1] ? pac_pkg::TICK_PERIOD_SHORT : pac_pkg::TICK_PERIOD;
      p = p * (m[0] ? 1 : pac_pkg::STALE_DIVIDE);
      apb(1'b1, A_AUX, {m[1:0], 6'h00});
      cyc(p + 4);
      c = 0;
      repeat (2 * p) begin
        cyc(1);
        if (stale_advance === 1'b1) c++;
      end
      chk("tick_rate", c, 32'h00000002);
    end
    apb(1'b1, A_AUX, 8'h00);
  endtask : t_timer

  // masking, lockout and the timeout hold.
  task t_chan;
    @(posedge pclk);
    channel_stale <= 1'b1;
    one_char_cond <= 1'b1;
    cyc(3);
    chk("stale", stale_status, 32'h00000001);
    apb(1'b1, A_AUX, 8'h20);
    cyc(3);
    chk("stale_mask", {stale_status, single_char_irq}, 32'h0);
    @(posedge pclk);
    chan_wr_valid <= 1'b1;
    ecp_forward <= 1'b1;
    event36_req <= 1'b1;
    host_recovery <= 1'b1;
    apb(1'b1, A_AUX, 8'h00);
    cyc(2);
    chk("open", {fifo_accept, fifo_full_seen, event36, discard_byte},
      32'hA);
    apb(1'b1, A_AUX, 8'h10);
    cyc(2);
    chk("locked", {fifo_accept, fifo_full_seen, event36, discard_byte},
      32'h5);
    apb(1'b1, A_AUX, 8'h00);
    @(posedge pclk);
    timeout_event <= 1'b1;
    @(posedge pclk);
    timeout_event <= 1'b0;
    cyc(2);
    chk("timeout", {timeout_status, single_char_irq}, 32'h3);
    apb(1'b0, A_STAT, 8'h00);
    chk("status", rdat, 32'h00000007);
    apb(1'b1, A_AUX, 8'h08);
    cyc(2);
    chk("to_clear", timeout_status, 32'h00000000);
    @(posedge pclk);
    timeout_event <= 1'b1;
    cyc(4);
    chk("to_held", {timeout_status, single_char_irq}, 32'h0);
    @(posedge pclk);
    timeout_event <= 1'b0;
    apb(1'b1, A_AUX, 8'h00);
  endtask : t_chan

  // grant path, direct and through the synchroniser.
  task t_dma;
    @(posedge pclk);
    dma_grant_n <= 1'b0;
    cyc(2);
    chk("dma_direct", dma_grant, 32'h00000001);
    apb(1'b1, A_AUX, 8'h02);
    @(posedge pclk);
    dma_grant_n <= 1'b1;
    cyc(1);
    chk("dma_sync_lag", dma_grant, 32'h00000001);
    cyc(8);
    chk("dma_sync", dma_grant, 32'h00000000);
  endtask : t_dma

  // Main sequence: six cycles of reset, then each scenario in turn.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ack();
    t_fair();
    t_timer();
    t_chan();
    t_dma();
    wrap_up();
  end
endmodule : tb_parallel_aux_control_and_vector
